// *** focrc_regs.svh ***
// Constants for the fast over-current retry controller.
// Assumes inclusion by the package and the controller only.
// Overview of operation
// - Retry code: limit current for delay time
// - Still limiting after delay: shut down, retry
// - Retry count zero: stay off until cleared
// - Codes one to six: that many attempts
// - Code seven: retry until off or fault
// - Attempts spaced by count times unit
// - Delay code n gives two-to-n units
// - One count for hold time and spacing
// - Unit length from separate unit register
// - Unit field bits 3:2: 1,4,16,256 ms
// - Any response sets fault status bit
`ifndef FOCRC_REGS_SVH
`define FOCRC_REGS_SVH
`define FOCRC_RESP_ADDR      8'hca
`define FOCRC_UNIT_ADDR      8'hc8
`define FOCRC_RESP_RST       8'h00
`define FOCRC_UNIT_RST       8'h00
`define FOCRC_RESP_MODE_HI   7
`define FOCRC_RESP_MODE_LO   6
`define FOCRC_RETRY_HI       5
`define FOCRC_RETRY_LO       3
`define FOCRC_DLY_HI         2
`define FOCRC_DLY_LO         0
`define FOCRC_IUNIT_HI       3
`define FOCRC_IUNIT_LO       2
`define FOCRC_MODE_RETRY     2'h3
`define FOCRC_RETRY_NONE     3'h0
`define FOCRC_RETRY_FOREVER  3'h7
`define FOCRC_CLK_MHZ        200
`define FOCRC_MS_CYCLES      (`FOCRC_CLK_MHZ * 1000)
`endif

// *** focrc_pkg.sv ***
// Types for the fast over-current retry controller.
// Assumes the constants header sits beside it.
`include "focrc_regs.svh"
package focrc_pkg;
  typedef enum logic [2:0] {
    FOCRC_IDLE  = 3'b000,
    FOCRC_LIMIT = 3'b001,
    FOCRC_WAIT  = 3'b010,
    FOCRC_START = 3'b011,
    FOCRC_LATCH = 3'b100
  } focrc_state_e;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } focrc_wr_s;

  typedef struct packed {
    logic enable;
    logic limit;
    logic fault;
  } focrc_pwr_s;
endpackage : focrc_pkg

// *** focrc_ctrl.sv ***
// Fast over-current fault response and retry sequencer.
// Assumes a command decoder delivering byte writes on this clock,
// and analog fault / limit flags arriving asynchronously.
`timescale 1ns/1ps
`include "focrc_regs.svh"
module focrc_ctrl #(
  parameter int unsigned MS_CYCLES = `FOCRC_MS_CYCLES
) (
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  input  wire focrc_pkg::focrc_wr_s  wr_i,
  input  wire logic                  oc_fault_i,
  input  wire logic                  oc_limiting_i,
  input  wire logic                  run_cmd_i,
  input  wire logic                  other_fault_i,
  input  wire logic                  fault_clear_i,
  output logic [7:0]                 resp_cfg_o,
  output logic [7:0]                 unit_cfg_o,
  output focrc_pkg::focrc_pwr_s      pwr_o,
  output logic                       fault_status_o,
  output logic [2:0]                 attempts_o
);
  import focrc_pkg::*;

  logic [1:0] rst_sync_r;
  logic       rst_n;
  logic [1:0] flt_s1_r, flt_s2_r;
  logic       flt_in, lim_in;

  // Reset leaves through two flops; logic starts two edges late
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Pins from the analog stage pass two flops
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flt_s1_r <= 2'h0;
      flt_s2_r <= 2'h0;
    end else begin
      flt_s1_r <= {oc_limiting_i, oc_fault_i};
      flt_s2_r <= flt_s1_r;
    end
  end
  assign flt_in = flt_s2_r[0];
  assign lim_in = flt_s2_r[1];

  // Register file
  logic [7:0] resp_r, resp_nxt, unit_r, unit_nxt;
  always_comb begin
    resp_nxt = resp_r;
    unit_nxt = unit_r;
    if (wr_i.wr && wr_i.addr == `FOCRC_RESP_ADDR) begin
      resp_nxt = wr_i.data;
    end
    if (wr_i.wr && wr_i.addr == `FOCRC_UNIT_ADDR) begin
      unit_nxt = wr_i.data;
    end
  end

  // Decoded delay: units (2^n) times ms per unit
  logic [2:0]  dly_code;
  logic [1:0]  unit_code;
  logic [7:0]  dly_units;
  logic [8:0]  ms_per_unit;
  logic [15:0] dly_ms;
  assign dly_code  = resp_r[`FOCRC_DLY_HI:`FOCRC_DLY_LO];
  assign unit_code = unit_r[`FOCRC_IUNIT_HI:`FOCRC_IUNIT_LO];
  assign dly_units = 8'h01 << dly_code;
  always_comb begin
    case (unit_code)
      2'h0:    ms_per_unit = 9'h001;
      2'h1:    ms_per_unit = 9'h004;
      2'h2:    ms_per_unit = 9'h010;
      default: ms_per_unit = 9'h100;
    endcase
  end
  // Same count serves hold time and retry spacing
  assign dly_ms = 16'(dly_units * ms_per_unit);

  // Sequencer with ms prescaler
  focrc_state_e st_r, st_nxt;
  logic [31:0]  pre_r, pre_nxt;
  logic [15:0]  ms_r, ms_nxt;
  logic [2:0]   att_r, att_nxt;
  logic         stat_r, stat_nxt;
  logic         en_r, en_nxt, lim_r, lim_nxt;
  logic         fault_r, fault_nxt;
  logic [2:0]   retries;
  logic         tick, expired;

  assign retries = resp_r[`FOCRC_RETRY_HI:`FOCRC_RETRY_LO];
  // Ends on the last tick of the last ms of the delay
  assign tick    = (pre_r == MS_CYCLES - 1);
  assign expired = tick && (ms_r >= dly_ms - 16'h0001);

  always_comb begin
    st_nxt   = st_r;
    pre_nxt  = tick ? 32'h0 : pre_r + 32'h1;
    ms_nxt   = tick ? ms_r + 16'h0001 : ms_r;
    att_nxt  = att_r;
    stat_nxt = stat_r;
    en_nxt   = run_cmd_i;
    lim_nxt  = 1'b0;
    // Status set wins over a clear in the same cycle
    if (fault_clear_i) begin
      stat_nxt = 1'b0;
    end
    if (flt_in) begin
      stat_nxt = 1'b1;
    end

    case (st_r)
      FOCRC_IDLE: begin
        if (run_cmd_i && flt_in &&
            resp_r[`FOCRC_RESP_MODE_HI:`FOCRC_RESP_MODE_LO]
              == `FOCRC_MODE_RETRY) begin
          st_nxt  = FOCRC_LIMIT;
          pre_nxt = 32'h0;
          ms_nxt  = 16'h0;
          lim_nxt = 1'b1;
        end
      end
      FOCRC_LIMIT: begin
        lim_nxt = 1'b1;
        if (!lim_in && !flt_in) begin
          st_nxt  = FOCRC_IDLE;
          lim_nxt = 1'b0;
        end else if (expired) begin
          lim_nxt = 1'b0;
          en_nxt  = 1'b0;
          pre_nxt = 32'h0;
          ms_nxt  = 16'h0;
          if (retries == `FOCRC_RETRY_NONE ||
              (retries != `FOCRC_RETRY_FOREVER && att_r >= retries)) begin
            st_nxt = FOCRC_LATCH;
          end else begin
            st_nxt = FOCRC_WAIT;
          end
        end
      end
      // Off time is one full delay; a failing attempt adds its hold
      FOCRC_WAIT: begin
        en_nxt = 1'b0;
        if (expired) begin
          st_nxt  = FOCRC_START;
          en_nxt  = run_cmd_i;
          if (retries != `FOCRC_RETRY_FOREVER) begin
            att_nxt = att_r + 3'h1;
          end
        end
      end
      FOCRC_START: begin
        pre_nxt = 32'h0;
        ms_nxt  = 16'h0;
        st_nxt  = flt_in ? FOCRC_LIMIT : FOCRC_IDLE;
        lim_nxt = flt_in;
      end
      FOCRC_LATCH: begin
        en_nxt = 1'b0;
        if (fault_clear_i) begin
          st_nxt = FOCRC_IDLE;
        end
      end
      default: st_nxt = FOCRC_IDLE;
    endcase

    // Off command or other fault end any sequence
    if (!run_cmd_i || other_fault_i) begin
      st_nxt  = FOCRC_IDLE;
      en_nxt  = 1'b0;
      lim_nxt = 1'b0;
    end

    // Count survives one cycle after START so a clean restart shows it
    if (!run_cmd_i || fault_clear_i || st_nxt == FOCRC_IDLE) begin
      if (st_r != FOCRC_START || !run_cmd_i || fault_clear_i) begin
        att_nxt = 3'h0;
      end
    end
    // Latched flag kept in a flop so the output is registered
    fault_nxt = (st_nxt == FOCRC_LATCH);
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      resp_r <= `FOCRC_RESP_RST;
      unit_r <= `FOCRC_UNIT_RST;
      st_r   <= FOCRC_IDLE;
      pre_r  <= 32'h0;
      ms_r   <= 16'h0;
      att_r  <= 3'h0;
      stat_r <= 1'b0;
      en_r   <= 1'b0;
      lim_r  <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      resp_r <= resp_nxt;
      unit_r <= unit_nxt;
      st_r   <= st_nxt;
      pre_r  <= pre_nxt;
      ms_r   <= ms_nxt;
      att_r  <= att_nxt;
      stat_r <= stat_nxt;
      en_r   <= en_nxt;
      lim_r  <= lim_nxt;
      fault_r <= fault_nxt;
    end
  end

  assign resp_cfg_o     = resp_r;
  assign unit_cfg_o     = unit_r;
  assign pwr_o          = '{
    enable: en_r,
    limit:  lim_r,
    fault:  fault_r
  };
  assign fault_status_o = stat_r;
  assign attempts_o     = att_r;
endmodule : focrc_ctrl

// *** focrc_chk.sv ***
// Port checker for the fast over-current retry controller.
// Assumes the controller's port names; bound below.
`timescale 1ns/1ps
module focrc_chk (
  input wire logic                  clk_i,
  input wire logic                  rstn_i,
  input wire focrc_pkg::focrc_wr_s  wr_i,
  input wire logic                  oc_fault_i,
  input wire logic                  run_cmd_i,
  input wire logic                  other_fault_i,
  input wire logic                  fault_clear_i,
  input wire logic [7:0]            resp_cfg_o,
  input wire logic [7:0]            unit_cfg_o,
  input wire focrc_pkg::focrc_pwr_s pwr_o,
  input wire logic                  fault_status_o,
  input wire logic [2:0]            attempts_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_resp_write: assert property (
    wr_i.wr && wr_i.addr == 8'hca |=> resp_cfg_o == $past(wr_i.data))
    else $error("response write lost");
  a_unit_write: assert property (
    wr_i.wr && wr_i.addr == 8'hc8 |=> unit_cfg_o == $past(wr_i.data))
    else $error("unit write lost");
  a_limit_mode: assert property (
    $rose(pwr_o.limit) |-> $past(resp_cfg_o[7:6]) == 2'h3)
    else $error("limit without retry mode");
  a_limit_runs: assert property (
    pwr_o.limit |-> pwr_o.enable) else $error("limit while off");
  a_latch_off: assert property (
    pwr_o.fault |-> !pwr_o.enable) else $error("enabled while latched");
  a_latch_hold: assert property (
    pwr_o.fault && !fault_clear_i && run_cmd_i && !other_fault_i
    |=> pwr_o.fault) else $error("latch left without clear");
  a_latch_count: assert property (
    $rose(pwr_o.fault) |-> attempts_o == resp_cfg_o[5:3])
    else $error("wrong attempt count at latch");
  a_forever_on: assert property (
    pwr_o.fault |-> resp_cfg_o[5:3] != 3'h7)
    else $error("latched in endless mode");
  a_status_set: assert property (
    $rose(oc_fault_i) |-> ##[2:4] fault_status_o)
    else $error("status not set");
  a_off_clears: assert property (
    !run_cmd_i |=> attempts_o == 3'h0)
    else $error("attempts kept after off");
  a_stop_disables: assert property (
    !run_cmd_i || other_fault_i |=> !pwr_o.enable && !pwr_o.limit)
    else $error("output left on after stop");
endmodule : focrc_chk
bind focrc_ctrl focrc_chk chk_i (.clk_i, .rstn_i, .wr_i, .oc_fault_i,
  .run_cmd_i, .other_fault_i, .fault_clear_i, .resp_cfg_o, .unit_cfg_o,
  .pwr_o, .fault_status_o, .attempts_o);

// *** focrc_host.sv ***
// Host model issuing single-byte configuration writes.
// Assumes calls only after the controller's reset settles.
`timescale 1ns/1ps
module focrc_host (
  input  wire logic            clk_i,
  output focrc_pkg::focrc_wr_s wr_o
);
  initial wr_o = '0;
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_o <= '{1'b1, a, d};
    @(posedge clk_i);
    // Released lines must not keep the old byte
    wr_o <= '{1'b0, ~a, ~d};
  endtask : put
endmodule : focrc_host

// *** tb_fast_overcurrent_retry_control.sv ***
// Bench: random delay settings, every retry code, mode refusal.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
module tb_fast_overcurrent_retry_control;
  import focrc_pkg::*;
  localparam int MS = 4;
  logic       clk_i = 0, rstn_i = 0, oc_f = 0, oc_l = 0;
  logic       run = 0, oth = 0, clr = 0, fs;
  logic [7:0] resp, unit, p, u;
  logic [2:0] att;
  focrc_wr_s  wr;
  focrc_pwr_s pwr;
  int n_fail = 0, samples_checked = 0, lc = 0, oc = 0;
  int n_att = 0, dly = 0, cyc = 0, off = 0;
  always #2.5 clk_i = ~clk_i;
  focrc_host host (.clk_i(clk_i), .wr_o(wr));
  focrc_ctrl #(.MS_CYCLES(MS)) uut (.clk_i(clk_i), .rstn_i(rstn_i),
    .wr_i(wr), .oc_fault_i(oc_f), .oc_limiting_i(oc_l), .run_cmd_i(run),
    .other_fault_i(oth), .fault_clear_i(clr), .resp_cfg_o(resp),
    .unit_cfg_o(unit), .pwr_o(pwr), .fault_status_o(fs), .attempts_o(att));
  function automatic int d_of(logic [7:0] pr, logic [7:0] ur);
    int m[4] = '{1, 4, 16, 256};
    return (1 << pr[2:0]) * m[ur[3:2]] * MS;
  endfunction : d_of
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      stop_test();
    end
    if (pwr.limit) lc++;
    else if (lc > 0) begin
      chk(lc, dly);
      lc = 0;
      off = 1;
      oc = 0;
    end
    // Latch or off command ends a retry gap without a restart
    if (pwr.fault || !run) off = 0;
    if (off && pwr.enable) begin
      chk(oc, dly);
      off = 0;
      n_att++;
    end else if (off) oc++;
  end
  initial begin
    void'($urandom(88));
    repeat (6) @(posedge clk_i);
    rstn_i <= 1;
    run <= 1;
    repeat (3) @(posedge clk_i);
    chk(resp, 8'h00);
    u = {4'ha, 2'($urandom_range(1)), 2'h3};
    host.put(8'hc8, u);
    host.put(8'hcb, 8'hff);
    @(posedge clk_i);
    chk(unit, u);
    chk(resp, 8'h00);
    $display("register setup done");
    for (int r = 0; r < 8; r++) begin
      p = {2'h3, 3'(r), r == 0 ? 3'h0 : 3'($urandom_range(2))};
      host.put(8'hca, p);
      dly = d_of(p, u);
      n_att = 0;
      off = 0;
      oc_f <= 1;
      oc_l <= 1;
      if (r < 7) begin
        wait (pwr.fault);
        @(posedge clk_i);
        chk(n_att, r);
        chk(pwr.enable, 0);
        chk(fs, 1);
        oc_f <= 0;
        oc_l <= 0;
        repeat (4) @(posedge clk_i);
        clr <= 1;
        @(posedge clk_i);
        clr <= 0;
        repeat (3) @(posedge clk_i);
        chk({pwr.fault, att}, 0);
      end else begin
        repeat (6 * dly + 20) @(posedge clk_i);
        chk({n_att >= 3, pwr.fault}, 2'b10);
        wait (!pwr.enable);
        @(posedge clk_i);
        run <= 0;
        repeat (3) @(posedge clk_i);
        chk({pwr.enable, att}, 0);
      end
      $display("retry code %0d done", r);
    end
    oc_f <= 0;
    oc_l <= 0;
    repeat (3) @(posedge clk_i);
    run <= 1;
    clr <= 1;
    @(posedge clk_i);
    clr <= 0;
    @(posedge clk_i);
    chk(fs, 0);
    host.put(8'hca, {2'($urandom_range(2)), 6'h3f});
    oc_f <= 1;
    repeat (10) @(posedge clk_i);
    chk({pwr.limit, pwr.enable, fs}, 3'b011);
    $display("refused mode done");
    stop_test();
  end
endmodule : tb_fast_overcurrent_retry_control
